// ===== src/ppm_pkg.sv
// What this block does
// - power state field reads current, writes new; 0 on, 3 hot low-power
// - power state codes 1 and 2 are reserved, unsupported states
// - capability bits 25 and 26 read zero, no D1/D2 support
// - wake support field bits 31:27 resets to 0b11001
// - no wake messages forwarded while cold powered-off
// - writes to wake support field change only advertised value
// - context preserved flag bit 3 defaults to one
// - wake enable bit 8 allows wake generation; cleared suppresses it
// - wake enable is sticky; hot reset keeps it, cold reset clears it
// - wake status bit 15 set on own wake event; write one clears
// - relayed wake messages leave wake status unchanged
// - upstream port never sets wake status
// - device specific init flag bit 21 defaults zero, lockable
// - data select, scale and data byte read zero
// - auxiliary current field bits 24:22 reads zero
// - legacy bus bits 22 and 23 of control register read zero
// - capability low byte reads 0x1
`default_nettype none
package ppm_pkg;
  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] PPM_OFS_CAP  = 8'hc0;
  localparam logic [7:0] PPM_OFS_CSR  = 8'hc4;
  localparam logic [7:0] PPM_OFS_ISTS = 8'he0;
  localparam logic [7:0] PPM_OFS_IEN  = 8'he4;
  localparam logic [7:0] PPM_OFS_ICLR = 8'he8;
  localparam logic [7:0] PPM_OFS_LOCK = 8'hec;

  // ************************************************************
  // fields and reset values
  // ************************************************************
  localparam int PPM_CAP_DSI_BIT    = 21;
  localparam int PPM_CAP_WAKE_LSB   = 27;
  localparam int PPM_CSR_CTX_BIT    = 3;
  localparam int PPM_CSR_WEN_BIT    = 8;
  localparam int PPM_CSR_WST_BIT    = 15;
  localparam logic [7:0]  PPM_CAP_ID       = 8'h01;
  localparam logic [7:0]  PPM_CAP_NEXT_US  = 8'h00;
  localparam logic [7:0]  PPM_CAP_NEXT_DS  = 8'hd0;
  localparam logic [2:0]  PPM_CAP_VER      = 3'h3;
  localparam logic [4:0]  PPM_WAKE_RST     = 5'h19;
  localparam logic [1:0]  PPM_PS_D0        = 2'h0;
  localparam logic [1:0]  PPM_PS_D3HOT     = 2'h3;
  localparam logic        PPM_CTX_RST      = 1'h1;
  localparam logic        PPM_DSI_RST      = 1'h0;
  // irq bits: 0 wake status set, 1 power state changed, 2 reserved write
  localparam int PPM_IRQ_W = 3;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } ppm_req_type;

  typedef struct packed {
    logic [1:0]  power_state_field;
    logic        ctx_keep;
    logic        dsi;
    logic [7:0]  next_ptr;
    logic [4:0]  wake_adv;
    logic        lock;
    logic [PPM_IRQ_W-1:0] ists;
    logic [PPM_IRQ_W-1:0] ien;
    logic [31:0] rdata;
  } ppm_warm_type;

  typedef struct packed {
    logic wen;
    logic wst;
  } ppm_sticky_type;

  // whole state of the block, registered as one word
  typedef struct packed {
    ppm_sticky_type sticky;
    ppm_warm_type   warm;
  } ppm_state_type;
endpackage
`default_nettype wire

// ===== src/ppm_regs.sv
`timescale 1ns/1ps
`default_nettype none
module ppm_regs #(
  parameter bit UPSTREAM = 1'b0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         hot_rst_n,
  input  wire ppm_pkg::ppm_req_type req,
  output logic [31:0]       rdata,
  input  wire logic         wake_event,
  input  wire logic         wake_relay,
  input  wire logic         cold_off,
  output logic              wake_msg_send,
  output logic [1:0]        power_state,
  output logic              irq
);
  import ppm_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  // warm part falls back on hot reset as well as on cold reset
  localparam ppm_warm_type WARM_RST = '{
    power_state_field: PPM_PS_D0,
    ctx_keep:          PPM_CTX_RST,
    dsi:               PPM_DSI_RST,
    next_ptr:          UPSTREAM ? PPM_CAP_NEXT_US : PPM_CAP_NEXT_DS,
    wake_adv:          PPM_WAKE_RST,
    lock:              1'b0,
    ists:              '0,
    ien:               '0,
    rdata:             32'h0000_0000
  };

  ppm_state_type        state_q;
  ppm_state_type        state_d;
  ppm_warm_type         w_q;
  ppm_warm_type         w_d;
  ppm_sticky_type       s_q;
  ppm_sticky_type       s_d;
  logic [31:0]          cap_v;
  logic [31:0]          csr_v;
  logic [PPM_IRQ_W-1:0] ev;
  logic                 own_wake;

  // views of the one state register
  assign w_q = state_q.warm;
  assign s_q = state_q.sticky;

  // upstream port originates nothing; relays never count
  assign own_wake = wake_event && !UPSTREAM;

  always_comb begin
    cap_v = 32'h0000_0000;
    cap_v[7:0] = PPM_CAP_ID;
    cap_v[15:8] = w_q.next_ptr;
    cap_v[18:16] = PPM_CAP_VER;
    cap_v[PPM_CAP_DSI_BIT] = w_q.dsi;
    cap_v[31:PPM_CAP_WAKE_LSB] = w_q.wake_adv;
    csr_v = 32'h0000_0000;
    csr_v[1:0] = w_q.power_state_field;
    csr_v[PPM_CSR_CTX_BIT] = w_q.ctx_keep;
    csr_v[PPM_CSR_WEN_BIT] = s_q.wen;
    csr_v[PPM_CSR_WST_BIT] = s_q.wst;
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    w_d = w_q;
    s_d = s_q;
    ev = '0;
    if (req.wr) begin
      case (req.addr)
        PPM_OFS_CAP: begin
          if (!w_q.lock) begin
            w_d.next_ptr = req.wdata[15:8];
            w_d.dsi = req.wdata[PPM_CAP_DSI_BIT];
            // advertised only; generation ignores it
            w_d.wake_adv = req.wdata[31:PPM_CAP_WAKE_LSB];
          end
        end
        PPM_OFS_CSR: begin
          if (req.wdata[1:0] == PPM_PS_D0
              || req.wdata[1:0] == PPM_PS_D3HOT) begin
            w_d.power_state_field = req.wdata[1:0];
            ev[1] = (req.wdata[1:0] != w_q.power_state_field);
          end else begin
            ev[2] = 1'b1;
          end
          if (!w_q.lock) begin
            w_d.ctx_keep = req.wdata[PPM_CSR_CTX_BIT];
          end
          s_d.wen = req.wdata[PPM_CSR_WEN_BIT];
          if (req.wdata[PPM_CSR_WST_BIT]) begin
            s_d.wst = 1'b0;
          end
        end
        PPM_OFS_IEN:  w_d.ien = req.wdata[PPM_IRQ_W-1:0];
        PPM_OFS_ICLR: w_d.ists = w_q.ists & ~req.wdata[PPM_IRQ_W-1:0];
        PPM_OFS_LOCK: w_d.lock = req.wdata[0];
        default: ;
      endcase
    end
    // set beats a same-cycle clear
    if (own_wake) begin
      s_d.wst = 1'b1;
      ev[0] = 1'b1;
    end
    w_d.ists = w_d.ists | ev;
    w_d.rdata = 32'h0000_0000;
    if (req.rd) begin
      case (req.addr)
        PPM_OFS_CAP:  w_d.rdata = cap_v;
        PPM_OFS_CSR:  w_d.rdata = csr_v;
        PPM_OFS_ISTS: w_d.rdata = {{(32-PPM_IRQ_W){1'b0}}, w_q.ists};
        PPM_OFS_IEN:  w_d.rdata = {{(32-PPM_IRQ_W){1'b0}}, w_q.ien};
        PPM_OFS_LOCK: w_d.rdata = {31'h0000_0000, w_q.lock};
        default:      w_d.rdata = 32'h0000_0000;
      endcase
    end
    state_d.sticky = s_d;
    state_d.warm = w_d;
    // hot reset is synchronous; sticky bits ride through it
    if (!hot_rst_n) begin
      state_d.warm = WARM_RST;
    end
  end

  // ************************************************************
  // registers: hot reset is folded into the next state above
  // ************************************************************
  // async branch loads constants only; sticky bits see cold reset alone
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= '{sticky: '0, warm: WARM_RST};
    end else begin
      state_q <= state_d;
    end
  end

  assign rdata = w_q.rdata;
  assign power_state = w_q.power_state_field;
  // generation follows enable, never the advertised field
  assign wake_msg_send = own_wake && s_q.wen && !cold_off;
  assign irq = |(w_q.ists & w_q.ien);

  // ************************************************************
  // checks
  // ************************************************************
  a_state_legal: assert property (
    @(posedge clk) disable iff (!rst_n)
    w_q.power_state_field == PPM_PS_D0
    || w_q.power_state_field == PPM_PS_D3HOT)
    else $error("power state holds a reserved code");
  a_rsvd_hold: assert property (
    @(posedge clk) disable iff (!rst_n || !hot_rst_n)
    req.wr && req.addr == PPM_OFS_CSR && req.wdata[1:0] inside {2'h1, 2'h2}
    |=> $stable(w_q.power_state_field))
    else $error("reserved write changed power state");
  a_wst_set: assert property (
    @(posedge clk) disable iff (!rst_n)
    own_wake |=> s_q.wst)
    else $error("wake status missed own event");
  a_wst_w1c: assert property (
    @(posedge clk) disable iff (!rst_n)
    req.wr && req.addr == PPM_OFS_CSR && req.wdata[PPM_CSR_WST_BIT]
    && !own_wake |=> !s_q.wst)
    else $error("wake status not cleared by write");
  a_relay_only: assert property (
    @(posedge clk) disable iff (!rst_n)
    wake_relay && !wake_event && !(req.wr && req.addr == PPM_OFS_CSR)
    |=> $stable(s_q.wst))
    else $error("relay changed wake status");
  a_up_never: assert property (
    @(posedge clk) disable iff (!rst_n)
    UPSTREAM |-> !s_q.wst)
    else $error("upstream wake status set");
  a_wen_hot: assert property (
    @(posedge clk) disable iff (!rst_n)
    !hot_rst_n && !(req.wr && req.addr == PPM_OFS_CSR)
    |=> s_q.wen == $past(s_q.wen))
    else $error("wake enable lost on hot reset");
  a_cold_quiet: assert property (
    @(posedge clk) disable iff (!rst_n)
    cold_off || !s_q.wen |-> !wake_msg_send)
    else $error("wake message sent while barred");
  a_ctx_locked: assert property (
    @(posedge clk) disable iff (!rst_n || !hot_rst_n)
    w_q.lock && req.wr && req.addr == PPM_OFS_CSR
    |=> $stable(w_q.ctx_keep))
    else $error("locked context flag changed");
  a_cap_fixed: assert property (
    @(posedge clk) disable iff (!rst_n || !hot_rst_n)
    req.rd && req.addr == PPM_OFS_CAP
    |=> rdata[7:0] == 8'h01 && rdata[26:22] == 5'h00)
    else $error("capability fixed bits wrong");
  a_csr_zero: assert property (
    @(posedge clk) disable iff (!rst_n)
    req.rd && req.addr == PPM_OFS_CSR
    |=> rdata[31:16] == 16'h0000 && rdata[14:9] == 6'h00)
    else $error("control register zero bits set");
endmodule
`default_nettype wire

// ===== dv/ppm_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ppm_regs_tb;
  import ppm_pkg::*;
  // ********
  // signals
  // ********
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hot_rst_n = 1'b1;
  ppm_req_type req;
  logic [31:0] rdata;
  logic [31:0] rdata_up;
  logic        wake_event = 1'b0;
  logic        wake_relay = 1'b0;
  logic        cold_off = 1'b0;
  logic        wake_msg_send;
  logic        send_up;
  logic [1:0]  power_state;
  logic        irq;
  int          num_errors = 0;
  int          comparisons = 0;
  logic [31:0] d;
  logic [1:0]  ps;

  ppm_regs #(.UPSTREAM(1'b0)) i_dut (.clk(clk), .rst_n(rst_n),
    .hot_rst_n(hot_rst_n), .req(req), .rdata(rdata), .wake_event(wake_event),
    .wake_relay(wake_relay), .cold_off(cold_off),
    .wake_msg_send(wake_msg_send), .power_state(power_state), .irq(irq));
  // upstream copy shares the bus; rd_chk checks rdata only, rdata_up is checked once for wake status
  ppm_regs #(.UPSTREAM(1'b1)) i_dut_up (.clk(clk), .rst_n(rst_n),
    .hot_rst_n(hot_rst_n), .req(req), .rdata(rdata_up),
    .wake_event(wake_event), .wake_relay(wake_relay), .cold_off(cold_off),
    .wake_msg_send(send_up), .power_state(), .irq());

  always #2.5 clk = ~clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      num_errors++;
    end
  endtask
  // control word as read back: state, context flag, enable, status clear
  function automatic logic [31:0] exp_csr(input logic [31:0] v,
                                          input logic [1:0]  s);
    exp_csr = {23'h0, v[8], 4'h0, v[3], 1'b0, s};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    req <= '{a, v, 1'b1, 1'b0};
    @(posedge clk);
    req <= '{a, v, 1'b0, 1'b0};
    #1;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk);
    req <= '{a, 32'h0, 1'b0, 1'b0};
    #1;
    chk(rdata, exp);
  endtask
  task automatic pulse(input logic relay, input logic exp);
    @(posedge clk);
    wake_event <= ~relay;
    wake_relay <= relay;
    #1;
    chk({31'h0, wake_msg_send}, {31'h0, exp});
    chk({31'h0, send_up}, 32'h0);
    @(posedge clk);
    wake_event <= 1'b0;
    wake_relay <= 1'b0;
    #1;
  endtask
  task automatic conclude();
    $display("num_errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ********
  // stimulus
  // ********
  initial begin
    req = '0;
    d = $urandom(32'hafdbdb37);
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(PPM_OFS_CAP, 32'hc803d001);
    rd_chk(PPM_OFS_CSR, 32'h00000008);
    rd_chk(8'h10, 32'h0);
    ps = PPM_PS_D0;
    // lock is open here, so the context flag follows every write
    repeat (20) begin
      d = $urandom();
      if (d[1:0] == 2'h0 || d[1:0] == 2'h3) ps = d[1:0];
      wr(PPM_OFS_CSR, d);
      chk({30'h0, power_state}, {30'h0, ps});
      rd_chk(PPM_OFS_CSR, exp_csr(d, ps));
    end
    wr(PPM_OFS_CSR, 32'h8);
    wr(PPM_OFS_ICLR, 32'h7);
    wr(PPM_OFS_IEN, 32'h4);
    // context flag stays up, so the readback below still holds it
    wr(PPM_OFS_CSR, 32'hb);
    for (int c = 1; c < 3; c++) wr(PPM_OFS_CSR, 32'h8 | c);
    chk({30'h0, power_state}, 32'h3);
    rd_chk(PPM_OFS_CSR, 32'h0000000b);
    rd_chk(PPM_OFS_ISTS, 32'h6);
    chk({31'h0, irq}, 32'h1);
    wr(PPM_OFS_ICLR, 32'h7);
    chk({31'h0, irq}, 32'h0);
    wr(PPM_OFS_IEN, 32'h1);
    wr(PPM_OFS_CSR, 32'h10b);
    pulse(1'b0, 1'b1);
    rd_chk(PPM_OFS_CSR, 32'h0000810b);
    chk(rdata_up & 32'h8000, 32'h0);
    chk({31'h0, irq}, 32'h1);
    @(posedge clk);
    cold_off <= 1'b1;
    pulse(1'b0, 1'b0);
    @(posedge clk);
    cold_off <= 1'b0;
    hot_rst_n <= 1'b0;
    @(posedge clk);
    hot_rst_n <= 1'b1;
    rd_chk(PPM_OFS_CSR, 32'h00008108);
    chk({30'h0, power_state}, 32'h0);
    wr(PPM_OFS_CSR, 32'h8108);
    pulse(1'b1, 1'b0);
    rd_chk(PPM_OFS_CSR, 32'h00000108);
    wr(PPM_OFS_CSR, 32'h8);
    pulse(1'b0, 1'b0);
    rd_chk(PPM_OFS_CSR, 32'h00008008);
    wr(PPM_OFS_CSR, 32'h108);
    wr(PPM_OFS_CAP, 32'h0);
    rd_chk(PPM_OFS_CAP, 32'h00030001);
    pulse(1'b0, 1'b1);
    wr(PPM_OFS_LOCK, 32'h1);
    wr(PPM_OFS_CAP, 32'hffffffff);
    rd_chk(PPM_OFS_CAP, 32'h00030001);
    wr(PPM_OFS_CSR, 32'h100);
    rd_chk(PPM_OFS_CSR, 32'h00008108);
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(PPM_OFS_CSR, 32'h00000008);
    rd_chk(PPM_OFS_CAP, 32'hc803d001);
    // load after cold reset arms wake for a hot-plug exit
    wr(PPM_OFS_CSR, 32'h108);
    pulse(1'b0, 1'b1);
    rd_chk(PPM_OFS_CSR, 32'h00008108);
    conclude();
  end
  initial begin
    #100000;
    num_errors++;
    conclude();
  end
endmodule
`default_nettype wire
